// >>> inc/cmd_sel_consts.svh
// Constants of the drive command source selector: offsets, fields, codes, resets.
// Included by the package only; the design modules use its macros; definitions only.
`ifndef CMD_SEL_CONSTS_SVH
`define CMD_SEL_CONSTS_SVH

// Register byte offsets (one aligned word each)
`define OFS_GROUP_ACTION  8'h00
`define OFS_SEL_BASE      8'h04
`define OFS_SEL_LAST      8'h20
`define OFS_HOST_CMD      8'h24
`define OFS_MACRO_LEVEL   8'h28
`define OFS_STATUS        8'h2c
`define OFS_IRQ_STATUS    8'h30
`define OFS_IRQ_MASK      8'h34
`define OFS_CONTROL       8'h38

// Group action values
`define GRP_UNCHANGED     2'd0
`define GRP_MACRO         2'd1
`define GRP_DISABLE       2'd2

// Selector codes
`define SEL_MACRO         4'h0
`define SEL_DISABLE       4'h1
`define SEL_DI_FIRST      4'h2
`define SEL_DI_LAST       4'h5
`define SEL_HCW_FIRST     4'h6
`define SEL_HCW_LAST      4'ha
`define HCW_SEL_BIT_BASE  4'hb

// Host command word bits
`define HCW_COAST_BIT     1
`define HCW_JOG1_BIT      8
`define HCW_JOG2_BIT      9

// Per-function inactive levels (coast, inverted fault, inverted alarm high)
`define INACTIVE_LEVELS   8'h54
`define MACRO_LEVEL_RST   8'h54
`define HOST_CMD_RST      16'h0002
`define SEL_RST           4'h0

// Functions that accept host command word codes (fault, alarm, direction)
`define WIDE_SEL_MASK     8'ha8

// Reported codes
`define EXT_TRIP_CODE     8'h16
`define EXT_WARN_CODE     8'h0c

// Interrupt bit positions
`define IRQ_TRIP          0
`define IRQ_WARN          1
`define IRQ_COAST         2
`define IRQ_REJECT        3
`define IRQ_BITS          4

// Control register: bit 0 clears a latched trip
`define CTRL_TRIP_CLR     0

`endif

// >>> inc/cmd_sel_pkg.sv
// Types of the drive command source selector.
// Assumes cmd_sel_consts.svh is on the include path.
package cmd_sel_pkg;
  `include "cmd_sel_consts.svh"

  localparam int NUM_FUNC = 8;

  typedef logic [3:0] sel_code_t;
  typedef sel_code_t [NUM_FUNC-1:0] sel_arr_t;

  // Function index order of the selector array
  typedef enum logic [2:0] {
    FN_JOG1      = 3'd0,
    FN_JOG2      = 3'd1,
    FN_COAST     = 3'd2,
    FN_FAULT     = 3'd3,
    FN_FAULT_INV = 3'd4,
    FN_ALARM     = 3'd5,
    FN_ALARM_INV = 3'd6,
    FN_DIR       = 3'd7
  } func_idx_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_JOG  = 3'b010,
    ST_STOP = 3'b100
  } jog_state_t;
endpackage : cmd_sel_pkg

// >>> inc/sel_bus_if.sv
// Carrier between the selector registers and the source decoder.
// Assumes one clock domain; all members are same-clock logic.
`timescale 1ns/1ps
interface sel_bus_if;
  import cmd_sel_pkg::*;
  sel_arr_t    sel;
  logic [3:0]  din;
  logic [15:0] hcw;
  logic [7:0]  macro_level;
  logic [7:0]  level;
  modport regs (output sel, output din, output hcw, output macro_level, input level);
  modport dec  (input sel, input din, input hcw, input macro_level, output level);
endinterface : sel_bus_if

// >>> rtl/sel_decode.sv
// Source decoder: turns each function's selector code into a level.
// Assumes selector codes were range-checked when written.
`timescale 1ns/1ps
module sel_decode (
  sel_bus_if.dec bus
);
  import cmd_sel_pkg::*;

  localparam logic [7:0] INACT = `INACTIVE_LEVELS;
  localparam logic [7:0] WIDE  = `WIDE_SEL_MASK;

  for (genvar i = 0; i < NUM_FUNC; i++) begin : g_fn
    wire sel_code_t code    = bus.sel[i];
    wire [1:0]      di_idx  = 2'(code - `SEL_DI_FIRST);
    wire [3:0]      hcw_idx = 4'(code - `SEL_HCW_FIRST + `HCW_SEL_BIT_BASE);
    wire            is_di   = (code >= `SEL_DI_FIRST) && (code <= `SEL_DI_LAST);
    wire            is_hcw  = WIDE[i] && (code >= `SEL_HCW_FIRST) && (code <= `SEL_HCW_LAST);
    assign bus.level[i] = (code == `SEL_MACRO) ? bus.macro_level[i] :
                          is_di                ? bus.din[di_idx] :
                          is_hcw               ? bus.hcw[hcw_idx] :
                                                 INACT[i];
  end
endmodule : sel_decode

// >>> rtl/cmd_source_select.sv
// Drive command source selector: AHB-Lite registers, selector decode, jog/coast/trip/warning logic.
// Assumes discrete inputs are asynchronous pins; speed_ctrl_mode and at_zero_speed are mclk logic.
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module cmd_source_select (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [3:0]  discrete_input,
  input  wire logic        speed_ctrl_mode,
  input  wire logic        at_zero_speed,
  output logic             current_ctrl_en,
  output logic             contactor_close,
  output logic             ramp_accel,
  output logic             ramp_decel,
  output logic [1:0]       fixed_speed_sel,
  output logic             rotation_reverse,
  output logic             drive_trip,
  output logic [7:0]       external_trip_code,
  output logic             drive_warning,
  output logic [7:0]       external_warning_code,
  output logic             irq
);
  import cmd_sel_pkg::*;

  sel_bus_if sbus ();

  sel_decode u_dec (
    .bus (sbus.dec)
  );

  // Discrete input synchroniser, three stages
  logic [3:0] din_s1_q;
  logic [3:0] din_s2_q;
  logic [3:0] din_s3_q;
  logic [3:0] din_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      din_s1_q <= 4'h0;
      din_s2_q <= 4'h0;
      din_s3_q <= 4'h0;
    end else begin
      din_s1_q <= discrete_input;
      din_s2_q <= din_s1_q;
      din_s3_q <= din_s2_q;
    end
  end

  // A bit changes only once stages two and three agree
  for (genvar b = 0; b < 4; b++) begin : g_din
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        din_q[b] <= 1'b0;
      end else if (din_s2_q[b] == din_s3_q[b]) begin
        din_q[b] <= din_s3_q[b];
      end
    end
  end

  // AHB-Lite address phase capture
  logic       dp_wr_q;
  logic       dp_rd_q;
  logic       rd_done_q;
  logic [7:0] dp_addr_q;

  wire        addr_take = hsel && htrans[1] && hready;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dp_wr_q   <= 1'b0;
      dp_rd_q   <= 1'b0;
      rd_done_q <= 1'b0;
      dp_addr_q <= 8'h00;
    end else begin
      if (hreadyout) begin
        dp_wr_q <= addr_take && hwrite;
        dp_rd_q <= addr_take && !hwrite;
        if (addr_take) begin
          dp_addr_q <= haddr[7:0];
        end
      end
      rd_done_q <= dp_rd_q && !rd_done_q;
    end
  end

  // Reads take one wait state so data reflect any write just before
  assign hreadyout = !(dp_rd_q && !rd_done_q);
  assign hresp     = 1'b0;

  // Register decode
  wire        hi_zero    = (dp_addr_q[1:0] == 2'b00);
  wire        wr_grp     = dp_wr_q && (dp_addr_q == `OFS_GROUP_ACTION);
  wire        in_sel     = hi_zero && (dp_addr_q >= `OFS_SEL_BASE) && (dp_addr_q <= `OFS_SEL_LAST);
  wire [2:0]  sel_idx    = 3'((dp_addr_q - `OFS_SEL_BASE) >> 2);
  wire        wr_sel     = dp_wr_q && in_sel;
  wire        wr_hcw     = dp_wr_q && (dp_addr_q == `OFS_HOST_CMD);
  wire        wr_macro   = dp_wr_q && (dp_addr_q == `OFS_MACRO_LEVEL);
  wire        wr_istat   = dp_wr_q && (dp_addr_q == `OFS_IRQ_STATUS);
  wire        wr_imask   = dp_wr_q && (dp_addr_q == `OFS_IRQ_MASK);
  wire        wr_ctrl    = dp_wr_q && (dp_addr_q == `OFS_CONTROL);
  wire [7:0]  wide_mask  = `WIDE_SEL_MASK;
  wire [3:0]  sel_max    = wide_mask[sel_idx] ? `SEL_HCW_LAST : `SEL_DI_LAST;
  wire        sel_ok     = (hwdata[31:4] == 28'h0) && (hwdata[3:0] <= sel_max);
  wire        grp_ok     = (hwdata[31:2] == 30'h0) && (hwdata[1:0] != 2'd3);
  wire        reject_evt = (wr_sel && !sel_ok) || (wr_grp && !grp_ok);

  // Selector registers
  sel_arr_t    sel_q;
  logic [15:0] hcw_q;
  logic [7:0]  macro_q;

  for (genvar i = 0; i < NUM_FUNC; i++) begin : g_sel
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        sel_q[i] <= `SEL_RST;
      end else if (wr_grp && grp_ok && (hwdata[1:0] == `GRP_MACRO)) begin
        sel_q[i] <= `SEL_MACRO;
      end else if (wr_grp && grp_ok && (hwdata[1:0] == `GRP_DISABLE)) begin
        sel_q[i] <= `SEL_DISABLE;
      end else if (wr_sel && sel_ok && (sel_idx == 3'(i))) begin
        sel_q[i] <= hwdata[3:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hcw_q   <= `HOST_CMD_RST;
      macro_q <= `MACRO_LEVEL_RST;
    end else begin
      if (wr_hcw) begin
        hcw_q <= hwdata[15:0];
      end
      if (wr_macro) begin
        macro_q <= hwdata[7:0];
      end
    end
  end

  assign sbus.sel         = sel_q;
  assign sbus.din         = din_q;
  assign sbus.hcw         = hcw_q;
  assign sbus.macro_level = macro_q;

  // Effective commands
  wire [7:0] lvl = sbus.level;
  wire jog1_cmd = lvl[FN_JOG1] | hcw_q[`HCW_JOG1_BIT];
  wire jog2_cmd = lvl[FN_JOG2] | hcw_q[`HCW_JOG2_BIT];
  wire coast_ok = lvl[FN_COAST] & hcw_q[`HCW_COAST_BIT];
  wire fault_now = lvl[FN_FAULT] | !lvl[FN_FAULT_INV];
  wire warn_now  = lvl[FN_ALARM] | !lvl[FN_ALARM_INV];
  wire jog_any   = jog1_cmd | jog2_cmd;

  // Latched trip, held until software clears it with the fault gone
  logic tripped_q;
  logic coast_ok_q;
  logic warn_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tripped_q  <= 1'b0;
      coast_ok_q <= 1'b0;
      warn_q     <= 1'b0;
    end else begin
      coast_ok_q <= coast_ok;
      warn_q     <= warn_now;
      if (fault_now) begin
        tripped_q <= 1'b1;
      end else if (wr_ctrl && hwdata[`CTRL_TRIP_CLR]) begin
        tripped_q <= 1'b0;
      end
    end
  end

  wire run_ok = coast_ok && !tripped_q && !fault_now;

  // Jog sequencer
  jog_state_t state_q;
  jog_state_t state_d;
  logic [1:0] spd_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (run_ok && jog_any) begin
          state_d = ST_JOG;
        end
      end
      ST_JOG: begin
        // coast or trip drops at once
        if (!run_ok) begin
          state_d = ST_IDLE;
        end else if (!jog_any) begin
          state_d = ST_STOP;
        end
      end
      ST_STOP: begin
        if (!run_ok) begin
          state_d = ST_IDLE;
        end else if (jog_any) begin
          state_d = ST_JOG;
        end else if (at_zero_speed) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      spd_q   <= 2'd0;
    end else begin
      state_q <= state_d;
      // Jog one wins when both are asked for
      if (state_d == ST_JOG) begin
        spd_q <= jog1_cmd ? 2'd1 : 2'd2;
      end
    end
  end

  // Drive action outputs
  logic dir_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      current_ctrl_en <= 1'b0;
      contactor_close <= 1'b0;
      ramp_accel      <= 1'b0;
      ramp_decel      <= 1'b0;
      fixed_speed_sel <= 2'd0;
      dir_q           <= 1'b0;
    end else begin
      // controller on while jogging or stopping
      current_ctrl_en <= (state_d != ST_IDLE);
      contactor_close <= run_ok;
      ramp_accel      <= (state_d == ST_JOG);
      ramp_decel      <= (state_d == ST_STOP);
      fixed_speed_sel <= (state_d == ST_JOG) ? (jog1_cmd ? 2'd1 : 2'd2) : 2'd0;
      if (speed_ctrl_mode) begin
        dir_q <= lvl[FN_DIR];
      end
    end
  end

  assign rotation_reverse      = dir_q;
  assign drive_trip            = tripped_q;
  assign external_trip_code    = tripped_q ? `EXT_TRIP_CODE : 8'h00;
  assign drive_warning         = warn_q;
  assign external_warning_code = warn_q ? `EXT_WARN_CODE : 8'h00;

  // Interrupt status, write one to clear; a new event wins over the clear
  logic [`IRQ_BITS-1:0] istat_q;
  logic [`IRQ_BITS-1:0] imask_q;
  wire  [`IRQ_BITS-1:0] ievt;

  assign ievt[`IRQ_TRIP]   = fault_now && !tripped_q;
  assign ievt[`IRQ_WARN]   = warn_now && !warn_q;
  assign ievt[`IRQ_COAST]  = coast_ok_q && !coast_ok;
  assign ievt[`IRQ_REJECT] = reject_evt;

  wire [`IRQ_BITS-1:0] iclr = wr_istat ? hwdata[`IRQ_BITS-1:0] : '0;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      istat_q <= '0;
      imask_q <= '0;
    end else begin
      istat_q <= (istat_q & ~iclr) | ievt;
      if (wr_imask) begin
        imask_q <= hwdata[`IRQ_BITS-1:0];
      end
    end
  end

  assign irq = |(istat_q & imask_q);

  // Read data, taken in the wait state of a read
  wire [31:0] status_word = {16'h0, state_q, dir_q, drive_warning, tripped_q,
                             contactor_close, current_ctrl_en, lvl};
  wire [31:0] sel_word    = {28'h0, sel_q[sel_idx]};
  wire [31:0] rd_mux      = in_sel                             ? sel_word :
                            (dp_addr_q == `OFS_HOST_CMD)       ? {16'h0, hcw_q} :
                            (dp_addr_q == `OFS_MACRO_LEVEL)    ? {24'h0, macro_q} :
                            (dp_addr_q == `OFS_STATUS)         ? status_word :
                            (dp_addr_q == `OFS_IRQ_STATUS)     ? {28'h0, istat_q} :
                            (dp_addr_q == `OFS_IRQ_MASK)       ? {28'h0, imask_q} :
                                                                 32'h0;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0;
    end else if (dp_rd_q && !rd_done_q) begin
      hrdata <= rd_mux;
    end
  end
endmodule : cmd_source_select

// >>> bench/drive_far_side.sv
// Far side model: discrete input pins and ramp feedback.
// Assumes the bench sets the pins on rising mclk edges.
`timescale 1ns/1ps
module drive_far_side #(
  parameter int DECEL_CYC = 8
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [3:0] pin_req,
  input  wire logic       ramp_decel,
  output logic      [3:0] discrete_input,
  output logic            at_zero_speed
);
  logic [3:0] cnt_q;
  assign discrete_input = pin_req;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) cnt_q <= 4'h0;
    else if (!ramp_decel) cnt_q <= 4'h0;
    else if (cnt_q != 4'(DECEL_CYC)) cnt_q <= cnt_q + 4'h1;
  end
  assign at_zero_speed = ramp_decel && (cnt_q == 4'(DECEL_CYC));
endmodule : drive_far_side

// >>> bench/cmd_source_select_checker.sv
// Port checker of the command source selector.
// Assumes one clock, mclk, and async reset rst_b.
`timescale 1ns/1ps
module cmd_source_select_checker (
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       at_zero_speed,
  input wire logic       speed_ctrl_mode,
  input wire logic       current_ctrl_en,
  input wire logic       contactor_close,
  input wire logic       ramp_accel,
  input wire logic       ramp_decel,
  input wire logic [1:0] fixed_speed_sel,
  input wire logic       rotation_reverse,
  input wire logic       drive_trip,
  input wire logic [7:0] external_trip_code,
  input wire logic       drive_warning,
  input wire logic [7:0] external_warning_code
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence stop_done_s; ramp_decel && at_zero_speed; endsequence
  // A new jog may take over at zero speed, so the controller follows the accel ramp
  sequence ctrl_settled_s; !ramp_decel && (current_ctrl_en == ramp_accel); endsequence
  sequence rd_req_s; hsel && htrans[1] && !hwrite && hready && hreadyout; endsequence
  stop_end_a: assert property (stop_done_s |=> ctrl_settled_s)
    else $error("controller on after zero speed");
  jog_run_a: assert property (ramp_accel |-> current_ctrl_en && fixed_speed_sel != 2'h0)
    else $error("jog without controller or setpoint");
  coast_off_a: assert property (!contactor_close |-> !current_ctrl_en)
    else $error("controller on with contactor open");
  trip_halt_a: assert property (drive_trip |-> !current_ctrl_en && !contactor_close)
    else $error("drive runs while tripped");
  trip_code_a: assert property (external_trip_code == (drive_trip ? 8'h16 : 8'h00))
    else $error("trip code wrong");
  warn_code_a: assert property (external_warning_code == (drive_warning ? 8'h0c : 8'h00))
    else $error("warning code wrong");
  dir_hold_a: assert property (!speed_ctrl_mode |=> $stable(rotation_reverse))
    else $error("direction moved outside speed control");
  read_wait_a: assert property (rd_req_s |=> !hreadyout ##1 hreadyout && !hresp)
    else $error("read wait state wrong");
endmodule : cmd_source_select_checker
bind cmd_source_select cmd_source_select_checker cmd_source_select_checker_i (
  .mclk, .rst_b, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .at_zero_speed,
  .speed_ctrl_mode, .current_ctrl_en, .contactor_close, .ramp_accel, .ramp_decel,
  .fixed_speed_sel, .rotation_reverse, .drive_trip, .external_trip_code, .drive_warning,
  .external_warning_code
);

// >>> bench/cmd_source_select_test.sv
// Self-checking bench of the command source selector.
// Assumes one AHB-Lite master (this bench) and the far side model.
`timescale 1ns/1ps
module cmd_source_select_test;
  logic mclk = 0, rst_b = 0, hsel = 0, hwrite = 0, mode = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0, fixed_speed_sel;
  logic [2:0] hsize = 3'h2;
  logic [3:0] pins = 0, din;
  logic hreadyout, hresp, azs, ctrl, cont, accel, decel, rev, trip, warn, irq;
  logic [7:0] tcode, wcode;
  int error_cnt = 0, checks = 0;
  always #10 mclk = ~mclk;
  cmd_source_select cmd_source_select_i (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .discrete_input(din),
    .speed_ctrl_mode(mode), .at_zero_speed(azs), .current_ctrl_en(ctrl), .contactor_close(cont),
    .ramp_accel(accel), .ramp_decel(decel), .fixed_speed_sel(fixed_speed_sel),
    .rotation_reverse(rev), .drive_trip(trip), .external_trip_code(tcode),
    .drive_warning(warn), .external_warning_code(wcode), .irq(irq));
  drive_far_side drive_far_side_i (.mclk(mclk), .rst_b(rst_b), .pin_req(pins),
    .ramp_decel(decel), .discrete_input(din), .at_zero_speed(azs));
  task end_of_test;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Ready is sampled mid-cycle, so it stands through the next rising edge
  task automatic hwait;
    int n;
    n = 0;
    @(negedge mclk);
    while (hreadyout !== 1'b1 && n < 40) begin
      n++;
      @(negedge mclk);
    end
    if (n == 40) begin
      error_cnt++;
      end_of_test();
    end
    @(posedge mclk);
  endtask : hwait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hwait();
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask : rc
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : wt
  task automatic pin(input logic [3:0] v, input int n);
    @(posedge mclk);
    pins <= v;
    wt(n);
  endtask : pin
  initial begin
    repeat (8) @(posedge mclk);
    rst_b <= 1;
    for (int i = 0; i < 8; i++) rc(8'(4 + 4 * i), 32'hff, 32'h0);
    rc(8'h24, 32'hffff, 32'h2);
    rc(8'h28, 32'hff, 32'h54);
    chk(cont, 1);
    wr(8'h04, 32'h6);
    rc(8'h04, 32'hf, 32'h0);
    wr(8'h10, 32'ha);
    wr(8'h10, 32'hb);
    rc(8'h10, 32'hf, 32'ha);
    rc(8'h30, 32'h8, 32'h8);
    wr(8'h34, 32'h8);
    wt(1);
    chk(irq, 1);
    wr(8'h30, 32'h8);
    wt(1);
    chk(irq, 0);
    wr(8'h00, 32'h3);
    wr(8'h00, 32'h2);
    for (int i = 0; i < 8; i++) rc(8'(4 + 4 * i), 32'hff, 32'h1);
    rc(8'h2c, 32'hff, 32'h54);
    wr(8'h00, 32'h0);
    rc(8'h20, 32'hf, 32'h1);
    wr(8'h00, 32'h1);
    rc(8'h20, 32'hf, 32'h0);
    wr(8'h04, 32'h2);
    pin(4'h1, 6);
    chk({accel, ctrl, 30'(fixed_speed_sel)}, {2'b11, 30'h1});
    pin(4'h0, 6);
    chk({decel, ctrl}, 2'b11);
    wt(12);
    chk(ctrl, 0);
    // Jog one off, else it shares input one with jog two and wins
    wr(8'h04, 32'h1);
    for (int k = 0; k < 4; k++) begin
      wr(8'h08, 32'(2 + k));
      pin(4'(1 << k), 7);
      chk(fixed_speed_sel, 2);
      pin(4'h0, 20);
      chk(ctrl, 0);
    end
    wr(8'h04, 32'h1);
    wr(8'h24, 32'h0102);
    wt(2);
    chk(fixed_speed_sel, 1);
    wr(8'h24, 32'h2);
    pin(4'h1, 20);
    chk(ctrl, 0);
    wr(8'h24, 32'h0);
    wt(2);
    chk(cont, 0);
    rc(8'h30, 32'h4, 32'h4);
    wr(8'h24, 32'h2);
    wr(8'h0c, 32'h4);
    pin(4'h0, 8);
    chk(cont, 0);
    pin(4'h4, 8);
    chk(cont, 1);
    for (int k = 0; k < 5; k++) begin
      wr(8'h10, 32'(6 + k));
      wr(8'h24, 32'h2 | (32'h1 << (11 + k)));
      wt(2);
      chk({trip, 24'h0, tcode}, {1'b1, 24'h0, 8'h16});
      wr(8'h24, 32'h2);
      wr(8'h38, 32'h1);
      wt(2);
      chk(trip, 0);
    end
    wr(8'h14, 32'h5);
    wt(2);
    chk(trip, 1);
    rc(8'h30, 32'h1, 32'h1);
    pin(4'hc, 8);
    wr(8'h38, 32'h1);
    wt(2);
    chk(trip, 0);
    // Command bit 15 still feeds the fault selector, so the alarm uses bit 14
    wr(8'h18, 32'h9);
    wr(8'h24, 32'h4002);
    wt(2);
    chk(wcode, 8'h0c);
    rc(8'h30, 32'h2, 32'h2);
    wr(8'h24, 32'h2);
    wt(2);
    chk({warn, trip}, 0);
    wr(8'h1c, 32'h3);
    wt(2);
    chk(warn, 1);
    pin(4'he, 8);
    chk(warn, 0);
    wr(8'h20, 32'h7);
    mode <= 1;
    wr(8'h24, 32'h1002);
    wt(2);
    chk(rev, 1);
    @(posedge mclk) mode <= 0;
    wr(8'h24, 32'h2);
    wt(2);
    chk(rev, 1);
    @(posedge mclk) mode <= 1;
    wt(2);
    chk(rev, 0);
    end_of_test();
  end
endmodule : cmd_source_select_test
